// ==== rtl/mmd_pkg.sv ====
// Purpose: constants and types for the memory map address decoder
// Assumes: 32-bit processor address; word-aligned register slots
// Notes: region bounds are kept as the nine-digit figures of the map
package mmd_pkg;

  //////////////////////////////////////////////////////////////////////////
  // address space regions, nine-digit figures
  localparam logic [35:0] ROM_LO_P = 36'h000000000;
  localparam logic [35:0] ROM_HI_P = 36'h03FFFFFFF;
  localparam logic [35:0] DRAM_LO_P = 36'h400000000;
  localparam logic [35:0] DRAM_HI_P = 36'h43FFFFFFF;
  localparam logic [35:0] MAP_LO_P = 36'h500000000;
  localparam logic [35:0] MAP_HI_P = 36'h50FFFFFFF;
  localparam logic [35:0] VID_LO_P = 36'h600000000;
  localparam logic [35:0] VID_HI_P = 36'h63FFFFFFF;
  localparam logic [35:0] PR0_LO_P = 36'h900000000;
  localparam logic [35:0] PR0_HI_P = 36'h90FFFFFFF;
  localparam logic [35:0] PR1_LO_P = 36'h910000000;
  localparam logic [35:0] PR1_HI_P = 36'h91FFFFFFF;
  localparam logic [35:0] PRX_LO_P = 36'h920000000;
  localparam logic [35:0] PRX_HI_P = 36'h95FFFFFFF;

  //////////////////////////////////////////////////////////////////////////
  // internal register window
  localparam logic [31:0] INT_BASE = 32'h80000000;
  localparam logic [31:0] INT_LAST = 32'h800000FC;

  // slot offsets from the internal base
  localparam logic [7:0] OFF_ROM_FIRST = 8'h00;
  localparam logic [7:0] OFF_ROM_LAST = 8'h04;
  localparam logic [7:0] OFF_DRAM_FIRST = 8'h08;
  localparam logic [7:0] OFF_DRAM_LAST = 8'h0C;
  localparam logic [7:0] OFF_MAP_FIRST = 8'h10;
  localparam logic [7:0] OFF_MAP_LAST = 8'h1C;
  localparam logic [7:0] OFF_ADAPTER0 = 8'h20;
  localparam logic [7:0] OFF_ADAPTER1 = 8'h24;
  localparam logic [7:0] OFF_INTC = 8'h28;
  localparam logic [7:0] OFF_DMA0_FIRST = 8'h30;
  localparam logic [7:0] OFF_DMA0_CTAIL = 8'h3C;
  localparam logic [7:0] OFF_DMA1_FIRST = 8'h40;
  localparam logic [7:0] OFF_DMA1_LAST = 8'h48;
  localparam logic [7:0] OFF_DMA0_ATAIL = 8'h70;
  localparam logic [7:0] OFF_SER_FIRST = 8'h80;
  localparam logic [7:0] OFF_SER_LAST = 8'h90;
  localparam logic [7:0] OFF_PARPORT_FIRST = 8'hA0;
  localparam logic [7:0] OFF_PARPORT_LAST = 8'hB0;
  localparam logic [7:0] OFF_OLDPP_CTL = 8'hC0;
  localparam logic [7:0] OFF_OLDPP_DAT = 8'hC4;
  localparam logic [7:0] OFF_OLDPP_STS = 8'hC8;
  localparam logic [7:0] OFF_PROGIO_FIRST = 8'hD0;
  localparam logic [7:0] OFF_PROGIO_LAST = 8'hDC;
  localparam logic [7:0] OFF_VID_FIRST = 8'hE0;
  localparam logic [7:0] OFF_VID_LAST = 8'hEC;

  // off-chip address pins
  localparam int EXT_AW = 22;

  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    MMD_U_NONE = 4'h0,
    MMD_U_ROM = 4'h1,
    MMD_U_DRAM = 4'h2,
    MMD_U_MAP = 4'h3,
    MMD_U_ADAPTER = 4'h4,
    MMD_U_INTC = 4'h5,
    MMD_U_DMA0 = 4'h6,
    MMD_U_DMA1 = 4'h7,
    MMD_U_SER = 4'h8,
    MMD_U_PARPORT = 4'h9,
    MMD_U_PROGIO = 4'hA,
    MMD_U_VID = 4'hB
  } mmd_unit_t;

  //////////////////////////////////////////////////////////////////////////
  // the nine-digit figures carry one extra low digit; drop it
  function automatic logic [31:0] mmd_bus_addr(input logic [35:0] p);
    return p[35:4];
  endfunction

  function automatic logic mmd_in(input logic [31:0] a,
                                  input logic [35:0] lo,
                                  input logic [35:0] hi);
    return (a >= mmd_bus_addr(lo)) && (a <= mmd_bus_addr(hi));
  endfunction

  function automatic logic mmd_off_in(input logic [7:0] o,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
    return (o >= lo) && (o <= hi);
  endfunction

endpackage

// ==== rtl/mmd_dec_if.sv ====
// Purpose: decode results passed from the leaf decoders to the top
// Assumes: all members are combinational from the current address
// Notes: none
`timescale 1ns/1ps
interface mmd_dec_if;
  logic rom;
  logic dram;
  logic mapped;
  logic intwin;
  logic pr0;
  logic pr1;
  logic prx;
  logic video;
  logic slot_ok;
  mmd_pkg::mmd_unit_t unit;

  modport region (output rom, dram, mapped, intwin, pr0, pr1, prx, video);
  modport slot (output slot_ok, unit);
  modport top (input rom, dram, mapped, intwin, pr0, pr1, prx, video,
               slot_ok, unit);
endinterface

// ==== rtl/mmd_region_dec.sv ====
// Purpose: combinational decode of the address space regions
// Assumes: addr is the current processor access address
// Notes: at most one region flag is high for any address
`timescale 1ns/1ps
module mmd_region_dec (
  input wire logic [31:0] addr,
  mmd_dec_if.region dec
);

  always_comb begin
    dec.rom = mmd_pkg::mmd_in(addr, mmd_pkg::ROM_LO_P, mmd_pkg::ROM_HI_P);
    dec.dram = mmd_pkg::mmd_in(addr, mmd_pkg::DRAM_LO_P,
                               mmd_pkg::DRAM_HI_P);
    dec.mapped = mmd_pkg::mmd_in(addr, mmd_pkg::MAP_LO_P,
                                 mmd_pkg::MAP_HI_P);
    dec.video = mmd_pkg::mmd_in(addr, mmd_pkg::VID_LO_P,
                                mmd_pkg::VID_HI_P);
    // every byte of the last word still belongs to the window
    dec.intwin = (addr >= mmd_pkg::INT_BASE)
                 && (addr[31:2] <= mmd_pkg::INT_LAST[31:2]);
    dec.pr0 = mmd_pkg::mmd_in(addr, mmd_pkg::PR0_LO_P, mmd_pkg::PR0_HI_P);
    dec.pr1 = mmd_pkg::mmd_in(addr, mmd_pkg::PR1_LO_P, mmd_pkg::PR1_HI_P);
    dec.prx = mmd_pkg::mmd_in(addr, mmd_pkg::PRX_LO_P, mmd_pkg::PRX_HI_P);
  end

endmodule

// ==== rtl/mmd_slot_dec.sv ====
// Purpose: decode of the internal register slots by offset
// Assumes: caller qualifies the result with the internal window flag
// Notes: byte bits of the offset are ignored
`timescale 1ns/1ps
module mmd_slot_dec (
  input wire logic [7:0] offset,
  mmd_dec_if.slot dec
);

  logic [7:0] o;

  always_comb begin
    o = {offset[7:2], 2'b00};
    dec.slot_ok = 1'b1;
    if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_ROM_FIRST,
                            mmd_pkg::OFF_ROM_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_ROM;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_DRAM_FIRST,
                                      mmd_pkg::OFF_DRAM_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_DRAM;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_MAP_FIRST,
                                      mmd_pkg::OFF_MAP_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_MAP;
    end else if (o == mmd_pkg::OFF_ADAPTER0) begin
      dec.unit = mmd_pkg::MMD_U_ADAPTER;
    end else if (o == mmd_pkg::OFF_INTC) begin
      dec.unit = mmd_pkg::MMD_U_INTC;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_DMA0_FIRST,
                                      mmd_pkg::OFF_DMA0_CTAIL)
                 || o == mmd_pkg::OFF_DMA0_ATAIL) begin
      dec.unit = mmd_pkg::MMD_U_DMA0;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_DMA1_FIRST,
                                      mmd_pkg::OFF_DMA1_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_DMA1;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_SER_FIRST,
                                      mmd_pkg::OFF_SER_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_SER;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_PARPORT_FIRST,
                                      mmd_pkg::OFF_PARPORT_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_PARPORT;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_PROGIO_FIRST,
                                      mmd_pkg::OFF_PROGIO_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_PROGIO;
    end else if (mmd_pkg::mmd_off_in(o, mmd_pkg::OFF_VID_FIRST,
                                      mmd_pkg::OFF_VID_LAST)) begin
      dec.unit = mmd_pkg::MMD_U_VID;
    end else begin
      // second adapter slot, old parallel slots and gaps all land here
      dec.unit = mmd_pkg::MMD_U_NONE;
      dec.slot_ok = 1'b0;
    end
  end

endmodule

// ==== rtl/mmd_decoder.sv ====
// Purpose: memory map address decoder, registered target selects
// Assumes: one access presented per cycle with acc_valid high
// Notes: selects appear one cycle after the access is presented
`timescale 1ns/1ps
module mmd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  output logic rom_sel,
  output logic dram_sel,
  output logic mapped_dram_sel,
  output logic intreg_sel,
  output mmd_pkg::mmd_unit_t intreg_unit,
  output logic [5:0] intreg_word,
  output logic periph_region0_select,
  output logic periph_region1_select,
  output logic unsup_region_hit,
  output logic video_memory_refused,
  output logic reserved_hit,
  output logic unsup_addr_trap,
  output logic [mmd_pkg::EXT_AW-1:0] ext_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  mmd_dec_if dec ();

  mmd_region_dec u_region (
    .addr(acc_addr),
    .dec(dec.region)
  );

  mmd_slot_dec u_slot (
    .offset(acc_addr[7:0]),
    .dec(dec.slot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next values

  logic rom_next;
  logic dram_next;
  logic mapped_next;
  logic intreg_next;
  mmd_pkg::mmd_unit_t unit_next;
  logic [5:0] word_next;
  logic pr0_next;
  logic pr1_next;
  logic prx_next;
  logic video_next;
  logic reserved_next;
  logic trap_next;
  logic [mmd_pkg::EXT_AW-1:0] ext_next;

  logic rom_reg;
  logic dram_reg;
  logic mapped_reg;
  logic intreg_reg;
  mmd_pkg::mmd_unit_t unit_reg;
  logic [5:0] word_reg;
  logic pr0_reg;
  logic pr1_reg;
  logic prx_reg;
  logic video_reg;
  logic reserved_reg;
  logic trap_reg;
  logic [mmd_pkg::EXT_AW-1:0] ext_reg;

  always_comb begin
    rom_next = acc_valid && dec.rom;
    dram_next = acc_valid && dec.dram;
    mapped_next = acc_valid && dec.mapped;
    // register select only for implemented slots of the window
    intreg_next = acc_valid && dec.intwin && dec.slot_ok;
    unit_next = intreg_next ? dec.unit : mmd_pkg::MMD_U_NONE;
    word_next = intreg_next ? acc_addr[7:2] : 6'h00;
    pr0_next = acc_valid && dec.pr0;
    pr1_next = acc_valid && dec.pr1;
    // no chip select pin exists for these regions
    prx_next = acc_valid && dec.prx;
    // no transfer cycle is started for the video memory range
    video_next = acc_valid && dec.video;
    trap_next = acc_valid && dec.intwin && !dec.slot_ok;
    reserved_next = acc_valid && !(dec.rom || dec.dram || dec.mapped
                    || dec.video || dec.intwin || dec.pr0 || dec.pr1
                    || dec.prx);
    // off-chip address carries the low 22 bits of ROM, DRAM, mapped and peripheral region 0/1 accesses only
    if (rom_next || dram_next || mapped_next || pr0_next
        || pr1_next) begin
      ext_next = acc_addr[mmd_pkg::EXT_AW-1:0];
    end else begin
      ext_next = ext_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rom_reg <= 1'b0;
      dram_reg <= 1'b0;
      mapped_reg <= 1'b0;
      intreg_reg <= 1'b0;
      unit_reg <= mmd_pkg::MMD_U_NONE;
      word_reg <= 6'h00;
      pr0_reg <= 1'b0;
      pr1_reg <= 1'b0;
      prx_reg <= 1'b0;
      video_reg <= 1'b0;
      reserved_reg <= 1'b0;
      trap_reg <= 1'b0;
      ext_reg <= '0;
    end else begin
      rom_reg <= rom_next;
      dram_reg <= dram_next;
      mapped_reg <= mapped_next;
      intreg_reg <= intreg_next;
      unit_reg <= unit_next;
      word_reg <= word_next;
      pr0_reg <= pr0_next;
      pr1_reg <= pr1_next;
      prx_reg <= prx_next;
      video_reg <= video_next;
      reserved_reg <= reserved_next;
      trap_reg <= trap_next;
      ext_reg <= ext_next;
    end
  end

  assign rom_sel = rom_reg;
  assign dram_sel = dram_reg;
  assign mapped_dram_sel = mapped_reg;
  assign intreg_sel = intreg_reg;
  assign intreg_unit = unit_reg;
  assign intreg_word = word_reg;
  assign periph_region0_select = pr0_reg;
  assign periph_region1_select = pr1_reg;
  assign unsup_region_hit = prx_reg;
  assign video_memory_refused = video_reg;
  assign reserved_hit = reserved_reg;
  assign unsup_addr_trap = trap_reg;
  assign ext_addr = ext_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [3:0] sel_count;
  assign sel_count = 4'(rom_sel) + 4'(dram_sel) + 4'(mapped_dram_sel)
                   + 4'(intreg_sel) + 4'(periph_region0_select)
                   + 4'(periph_region1_select);

  rom_range_a: assert property (
    acc_valid && acc_addr <= 32'h03FFFFFF |=> rom_sel && !dram_sel)
    else $error("ROM range not selected");

  dram_range_a: assert property (
    acc_valid && acc_addr >= 32'h40000000 && acc_addr <= 32'h43FFFFFF
    |=> dram_sel)
    else $error("DRAM range not selected");

  mapped_range_a: assert property (
    mapped_dram_sel |-> $past(acc_addr[31:24]) == 8'h50)
    else $error("mapped select outside its range");

  region0_cs_a: assert property (
    periph_region0_select == $past(acc_valid
      && acc_addr[31:24] == 8'h90))
    else $error("region zero select wrong");

  region1_cs_a: assert property (
    periph_region1_select == $past(acc_valid
      && acc_addr[31:24] == 8'h91))
    else $error("region one select wrong");

  unsup_region_a: assert property (
    acc_valid && acc_addr >= 32'h92000000 && acc_addr <= 32'h95FFFFFF
    |=> unsup_region_hit && sel_count == 4'h0)
    else $error("unsupported region got a select");

  video_none_a: assert property (
    video_memory_refused |-> sel_count == 4'h0 && !unsup_addr_trap)
    else $error("video range started a transfer");

  old_pp_trap_a: assert property (
    acc_valid && (acc_addr == 32'h800000C0 || acc_addr == 32'h800000C4
    || acc_addr == 32'h800000C8) |=> unsup_addr_trap && !intreg_sel)
    else $error("old parallel slot did not trap");

  pia1_slot_a: assert property (
    acc_valid && acc_addr == 32'h80000024 |=> unsup_addr_trap)
    else $error("second adapter slot not reserved");

  slot_trap_a: assert property (
    intreg_sel |-> !unsup_addr_trap && intreg_unit != mmd_pkg::MMD_U_NONE)
    else $error("trap and select together");

  dma0_tail_a: assert property (
    acc_valid && acc_addr == 32'h80000070
    |=> intreg_unit == mmd_pkg::MMD_U_DMA0)
    else $error("DMA zero address tail not selected");

  serial_slot_a: assert property (
    acc_valid && acc_addr == 32'h80000090
    |=> intreg_unit == mmd_pkg::MMD_U_SER && intreg_word == 6'h24)
    else $error("baud divisor slot not selected");

  ext_addr_a: assert property (
    $past(acc_valid) && rom_sel |-> ext_addr == $past(acc_addr[21:0]))
    else $error("external address wrong");

  reserved_a: assert property (
    reserved_hit |-> sel_count == 4'h0 ##1 1'b1)
    else $error("reserved range got a select");

  one_select_a: assert property (
    sel_count <= 4'h1)
    else $error("more than one target selected");

  idle_quiet_a: assert property (
    !acc_valid ##1 1'b1 |-> sel_count == 4'h0 && !unsup_addr_trap)
    else $error("select without an access");

  mapped_fwd_a: assert property (
    acc_valid && acc_addr >= 32'h50000000 && acc_addr <= 32'h50FFFFFF
    |=> mapped_dram_sel && sel_count == 4'h1)
    else $error("mapped range not selected");

  window_slot_a: assert property (
    acc_valid && acc_addr == 32'h80000028
    |=> intreg_sel && intreg_unit == mmd_pkg::MMD_U_INTC
    && intreg_word == 6'h0A)
    else $error("interrupt control slot not selected");

  rom_slot_a: assert property (
    acc_valid && acc_addr[31:3] == 29'h10000000
    |=> intreg_sel && intreg_unit == mmd_pkg::MMD_U_ROM)
    else $error("ROM register slot not selected");

  adapter_slot_a: assert property (
    acc_valid && acc_addr == 32'h80000020
    |=> intreg_sel && intreg_unit == mmd_pkg::MMD_U_ADAPTER)
    else $error("adapter control slot not selected");

  dma1_slot_a: assert property (
    acc_valid && acc_addr == 32'h80000044
    |=> intreg_unit == mmd_pkg::MMD_U_DMA1 && intreg_word == 6'h11)
    else $error("DMA one address slot not selected");

  map_slot_a: assert property (
    acc_valid && acc_addr[31:4] == 28'h8000001
    |=> intreg_sel && intreg_unit == mmd_pkg::MMD_U_MAP)
    else $error("mapping register slot not selected");

  parport_slot_a: assert property (
    acc_valid && acc_addr == 32'h800000A8
    |=> intreg_unit == mmd_pkg::MMD_U_PARPORT && intreg_word == 6'h2A)
    else $error("parallel interface slot not selected");

  progio_slot_a: assert property (
    acc_valid && acc_addr == 32'h800000DC
    |=> intreg_unit == mmd_pkg::MMD_U_PROGIO && intreg_word == 6'h37)
    else $error("I/O port slot not selected");

  video_slot_a: assert property (
    acc_valid && acc_addr == 32'h800000E4
    |=> intreg_unit == mmd_pkg::MMD_U_VID && intreg_word == 6'h39)
    else $error("video register slot not selected");

  trap_window_a: assert property (
    unsup_addr_trap
    |-> $past(acc_valid) && $past(acc_addr[31:8]) == 24'h800000)
    else $error("trap outside the register window");

  reserved_fwd_a: assert property (
    acc_valid && acc_addr >= 32'h64000000 && acc_addr <= 32'h7FFFFFFF
    |=> reserved_hit && sel_count == 4'h0 && !unsup_addr_trap)
    else $error("reserved range not flagged");

  ext_hold_a: assert property (
    !$past(rst) && !(rom_sel || dram_sel || mapped_dram_sel
    || periph_region0_select || periph_region1_select)
    |-> $stable(ext_addr))
    else $error("external address moved without an access");

  rom_cover_c: cover property (acc_valid ##1 rom_sel);
  intreg_cover_c: cover property (intreg_sel ##1 unsup_addr_trap);
  region1_cover_c: cover property (periph_region1_select);
  video_cover_c: cover property (video_memory_refused);
  unsup_cover_c: cover property (unsup_region_hit ##1 reserved_hit);

endmodule

// ==== sim/mmd_core_model.sv ====
// Purpose: processor core model presenting accesses to the decoder
// Assumes: caller invokes the tasks right after a rising clock edge
// Notes: while idle the address bus shows the inverted last address
`timescale 1ns/1ps
module mmd_core_model (
  output logic acc_valid,
  output logic [31:0] acc_addr
);
  logic [31:0] last_addr;

  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h00000000;
    last_addr = 32'h00000000;
  end

  //////////////////////////////////////////////////////////////////////////
  // no write data leaves this model, so reserved bits stay zero
  task automatic drive(input logic [31:0] a);
    acc_valid <= 1'b1;
    acc_addr <= a;
    last_addr = a;
  endtask

  // an idle bus carries no meaning; never let the old address linger
  task automatic idle();
    acc_valid <= 1'b0;
    acc_addr <= ~last_addr;
  endtask
endmodule

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the memory map address decoder
// Assumes: selects and flags appear exactly one cycle after an access
// Notes: expected decode is worked out here from the address map
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  logic acc_valid;
  logic [31:0] acc_addr;
  logic rom_sel;
  logic dram_sel;
  logic mapped_dram_sel;
  logic intreg_sel;
  mmd_pkg::mmd_unit_t intreg_unit;
  logic [5:0] intreg_word;
  logic periph_region0_select;
  logic periph_region1_select;
  logic unsup_region_hit;
  logic video_memory_refused;
  logic reserved_hit;
  logic unsup_addr_trap;
  logic [21:0] ext_addr;
  int n_fail;
  int cmp_count;
  logic [21:0] ext_exp;
  logic [31:0] addr_q[$];

  mmd_decoder mmd_decoder_inst (
    .clk(clk), .rst(rst), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .rom_sel(rom_sel), .dram_sel(dram_sel),
    .mapped_dram_sel(mapped_dram_sel), .intreg_sel(intreg_sel),
    .intreg_unit(intreg_unit), .intreg_word(intreg_word),
    .periph_region0_select(periph_region0_select),
    .periph_region1_select(periph_region1_select),
    .unsup_region_hit(unsup_region_hit),
    .video_memory_refused(video_memory_refused),
    .reserved_hit(reserved_hit), .unsup_addr_trap(unsup_addr_trap),
    .ext_addr(ext_addr)
  );

  mmd_core_model mmd_core_model_inst (
    .acc_valid(acc_valid),
    .acc_addr(acc_addr)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic mmd_pkg::mmd_unit_t exp_unit(input logic [7:0] o);
    if (o <= 8'h04) return mmd_pkg::MMD_U_ROM;
    if (o <= 8'h0C) return mmd_pkg::MMD_U_DRAM;
    if (o <= 8'h1C) return mmd_pkg::MMD_U_MAP;
    if (o == 8'h20) return mmd_pkg::MMD_U_ADAPTER;
    if (o == 8'h28) return mmd_pkg::MMD_U_INTC;
    if ((o >= 8'h30 && o <= 8'h3C) || o == 8'h70) return mmd_pkg::MMD_U_DMA0;
    if (o >= 8'h40 && o <= 8'h48) return mmd_pkg::MMD_U_DMA1;
    if (o >= 8'h80 && o <= 8'h90) return mmd_pkg::MMD_U_SER;
    if (o >= 8'hA0 && o <= 8'hB0) return mmd_pkg::MMD_U_PARPORT;
    if (o >= 8'hD0 && o <= 8'hDC) return mmd_pkg::MMD_U_PROGIO;
    if (o >= 8'hE0 && o <= 8'hEC) return mmd_pkg::MMD_U_VID;
    return mmd_pkg::MMD_U_NONE;
  endfunction

  // bits: rom dram map intreg pr0 pr1 unsup video reserved trap
  function automatic logic [9:0] exp_flags(input logic [31:0] a);
    if (a <= 32'h03FFFFFF) return 10'h200;
    if (a >= 32'h40000000 && a <= 32'h43FFFFFF) return 10'h100;
    if (a >= 32'h50000000 && a <= 32'h50FFFFFF) return 10'h080;
    if (a >= 32'h60000000 && a <= 32'h63FFFFFF) return 10'h004;
    if (a[31:8] == 24'h800000) begin
      if (exp_unit({a[7:2], 2'b00}) == mmd_pkg::MMD_U_NONE) return 10'h001;
      return 10'h040;
    end
    if (a[31:24] == 8'h90) return 10'h020;
    if (a[31:24] == 8'h91) return 10'h010;
    if (a >= 32'h92000000 && a <= 32'h95FFFFFF) return 10'h008;
    return 10'h002;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic check_out(input logic v, input logic [31:0] a);
    logic [9:0] f;
    logic [9:0] s;
    mmd_pkg::mmd_unit_t u;
    logic [5:0] w;
    f = v ? exp_flags(a) : 10'h000;
    u = mmd_pkg::MMD_U_NONE;
    w = 6'h00;
    if (f[6]) begin
      u = exp_unit({a[7:2], 2'b00});
      w = a[7:2];
    end
    if (|{f[9:7], f[5:4]}) ext_exp = a[21:0];
    s = {rom_sel, dram_sel, mapped_dram_sel, intreg_sel,
         periph_region0_select, periph_region1_select, unsup_region_hit,
         video_memory_refused, reserved_hit, unsup_addr_trap};
    chk(32'(s[9:7]), 32'(f[9:7])); // sel
    chk(32'(s[6:4]), 32'(f[6:4])); // win
    chk(32'(s[3:2]), 32'(f[3:2])); // none
    chk(32'(s[1:0]), 32'(f[1:0])); // trap
    chk(32'(intreg_unit), 32'(u)); // u
    chk(32'(intreg_word), 32'(w)); // slot
    chk(32'(ext_addr), 32'(ext_exp)); // pins
  endtask

  // back to back accesses, each judged one cycle later, then one idle
  task automatic send();
    for (int i = 0; i <= addr_q.size(); i++) begin
      @(posedge clk);
      if (i < addr_q.size()) mmd_core_model_inst.drive(addr_q[i]);
      else mmd_core_model_inst.idle();
      #1;
      if (i > 0) check_out(1'b1, addr_q[i-1]);
    end
    @(posedge clk);
    #1;
    check_out(1'b0, 32'h00000000);
    addr_q.delete();
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    repeat (11) @(posedge clk);
    #1;
    check_out(1'b0, 32'h00000000);
    @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
  endtask

  task automatic test_regions();
    addr_q = '{32'h00000000, 32'h03FFFFFF, 32'h04000000, 32'h40000000,
               32'h43FFFFFF, 32'h44000000, 32'h50000000, 32'h50FFFFFF,
               32'h51000000, 32'h60000000, 32'h63FFFFFF, 32'h64000000,
               32'h7FFFFFFF, 32'h90000000, 32'h90FFFFFF, 32'h91000000,
               32'h91FFFFFF, 32'h92000000, 32'h95FFFFFF, 32'h96000000,
               32'h80000100, 32'hFFFFFFFF, 32'h3FFFFFFF};
    send();
    $display("test regions done");
  endtask

  task automatic test_slots();
    for (int o = 0; o < 64; o++) begin
      addr_q.push_back({24'h800000, o[5:0], 2'b00});
    end
    addr_q.push_back(32'h80000093);
    addr_q.push_back(32'h80000026);
    addr_q.push_back(32'h800000C7);
    addr_q.push_back(32'h800000FF);
    send();
    $display("test slots done");
  endtask

  task automatic test_reset_mid();
    @(posedge clk);
    mmd_core_model_inst.drive(32'h90001234);
    @(posedge clk);
    mmd_core_model_inst.idle();
    rst <= 1'b1;
    #1;
    check_out(1'b1, 32'h90001234);
    @(posedge clk);
    #1;
    ext_exp = 22'h000000;
    check_out(1'b0, 32'h00000000);
    @(posedge clk);
    rst <= 1'b0;
    addr_q = '{32'h00000010, 32'h800000C0};
    send();
    $display("test reset mid done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    cmp_count = 0;
    ext_exp = 22'h000000;
    rst = 1'b1;
    do_reset();
    test_regions();
    test_slots();
    test_reset_mid();
    end_sim();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
